// file: logic/port_readback.sv
// Purpose: port data/direction registers, readback self-test path, bit ops, wake
// Assumes: pins synchronous to pclk; analog switch enables are plain levels
// Notes:   two 8-bit ports (A, B); analog channel 0 on A3, channel 1 on A1
`timescale 1ns/1ns
`default_nettype none
module port_readback
#(
    parameter int port_width = 8
)
(
    // apb
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  clk_en,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // port pins
    input  wire logic [port_width-1:0] porta_in,
    output logic      [port_width-1:0] porta_out,
    output logic      [port_width-1:0] porta_oen_n,
    input  wire logic [port_width-1:0] portb_in,
    output logic      [port_width-1:0] portb_out,
    output logic      [port_width-1:0] portb_oen_n,
    // function selection from the pin-shared mux
    input  wire logic [port_width-1:0] porta_digout_fn,
    input  wire logic [port_width-1:0] portb_digout_fn,
    // power state and analog switches
    input  wire logic                  sleep_mode,
    output logic                       wake_req,
    output logic      [1:0]            analog_switch_on
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]            key_r;
    logic                  pin_readback_mode_r;
    logic [port_width-1:0] porta_data_r;
    logic [port_width-1:0] portb_data_r;
    logic [port_width-1:0] porta_dir_r;
    logic [port_width-1:0] portb_dir_r;
    logic [port_width-1:0] porta_wake_enable_r;
    logic [port_width-1:0] porta_prev_r;
    logic [1:0]            chan_sel_r;
    logic [1:0]            analog_fn_sel_r;
    logic [7:0]            bitop_r;
    logic [port_width-1:0] bop_byte_r;
    port_readback_pkg::bop_state_type bop_state_r;

    logic                  wr_en;
    logic                  rd_en;
    logic                  addr_ok;
    logic                  bop_busy;
    logic [port_width-1:0] porta_view;
    logic [port_width-1:0] portb_view;
    logic [31:0]           rd_nxt;
    logic [port_width-1:0] bop_mod;
    logic [2:0]            bop_idx;

    assign bop_busy = (bop_state_r != port_readback_pkg::bop_idle);
    assign wr_en    = clk_en && psel && penable && pwrite && !pready && !bop_busy;
    assign rd_en    = clk_en && psel && penable && !pwrite && !pready;
    assign bop_idx  = bitop_r[port_readback_pkg::bitop_idx_lsb +: 3];

    // ------------------------------------------------------------
    // read view of a port
    // ------------------------------------------------------------
    // outside readback mode, analog-selected pins read 0; digital-output pins set as input read 0
    function automatic logic [port_width-1:0] port_view(
        input logic                  mode,
        input logic [port_width-1:0] pins,
        input logic [port_width-1:0] latch,
        input logic [port_width-1:0] dir,
        input logic [port_width-1:0] digout,
        input logic [port_width-1:0] ana
    );
        logic [port_width-1:0] v;
        v = '0;
        for (int i = 0; i < port_width; i++)
        begin
            if (mode)
                v[i] = pins[i];
            else if (ana[i])
                v[i] = 1'b0;
            else if (digout[i])
                v[i] = dir[i] ? 1'b0 : latch[i];
            else
                v[i] = dir[i] ? pins[i] : latch[i];
        end
        return v;
    endfunction

    logic [port_width-1:0] porta_ana;
    always_comb
    begin
        porta_ana    = '0;
        porta_ana[3] = analog_fn_sel_r[0];
        porta_ana[1] = analog_fn_sel_r[1];
    end

    assign porta_view = port_view(pin_readback_mode_r, porta_in, porta_data_r,
                                  porta_dir_r, porta_digout_fn, porta_ana);
    assign portb_view = port_view(pin_readback_mode_r, portb_in, portb_data_r,
                                  portb_dir_r, portb_digout_fn, '0);

    // ------------------------------------------------------------
    // apb handshake and read data
    // ------------------------------------------------------------
    always_comb
    begin
        addr_ok = 1'b1;
        rd_nxt  = 32'h0000_0000;
        case (paddr)
            port_readback_pkg::off_readback_key: rd_nxt[7:0] = key_r;
            port_readback_pkg::off_porta_data:   rd_nxt[port_width-1:0] = porta_data_r;
            port_readback_pkg::off_porta_dir:    rd_nxt[port_width-1:0] = porta_dir_r;
            port_readback_pkg::off_portb_data:   rd_nxt[port_width-1:0] = portb_data_r;
            port_readback_pkg::off_portb_dir:    rd_nxt[port_width-1:0] = portb_dir_r;
            port_readback_pkg::off_porta_wake:   rd_nxt[port_width-1:0] = porta_wake_enable_r;
            port_readback_pkg::off_porta_read:   rd_nxt[port_width-1:0] = porta_view;
            port_readback_pkg::off_portb_read:   rd_nxt[port_width-1:0] = portb_view;
            port_readback_pkg::off_analog_ctrl:  rd_nxt[5:0] = {analog_fn_sel_r, 2'b00, chan_sel_r};
            port_readback_pkg::off_bit_op:       rd_nxt[7:0] = bitop_r;
            port_readback_pkg::off_status:       rd_nxt[1:0] = {bop_busy, pin_readback_mode_r};
            default:                             addr_ok = 1'b0;
        endcase
    end

    // write waits while a bit operation runs; pready then stays low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (wr_en || rd_en)
            begin
                pready  <= 1'b1;
                pslverr <= !addr_ok;
                prdata  <= rd_en ? rd_nxt : 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // key register and readback mode
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            key_r               <= port_readback_pkg::key_reset;
            pin_readback_mode_r <= 1'b0;
        end
        else if (wr_en && paddr == port_readback_pkg::off_readback_key)
        begin
            key_r               <= pwdata[7:0];
            pin_readback_mode_r <= (pwdata[7:0] == port_readback_pkg::key_pattern);
        end
    end

    // ------------------------------------------------------------
    // bit set/clear sequencer
    // ------------------------------------------------------------
    // for data bits the byte is taken from the read view, so in readback mode the pin
    // levels get written into the latch: same hazard as the real core
    always_comb
    begin
        bop_mod = bop_byte_r;
        bop_mod[bop_idx] = bitop_r[port_readback_pkg::bitop_val_pos];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bop_state_r <= port_readback_pkg::bop_idle;
            bop_byte_r  <= '0;
            bitop_r     <= 8'h00;
        end
        else if (clk_en)
        begin
            case (bop_state_r)
                port_readback_pkg::bop_idle:
                begin
                    if (wr_en && paddr == port_readback_pkg::off_bit_op)
                    begin
                        bitop_r     <= pwdata[7:0];
                        bop_state_r <= port_readback_pkg::bop_read;
                    end
                end
                port_readback_pkg::bop_read:
                begin
                    if (bitop_r[port_readback_pkg::bitop_dir_pos])
                        bop_byte_r <= bitop_r[port_readback_pkg::bitop_port_pos]
                                      ? portb_dir_r : porta_dir_r;
                    else
                        bop_byte_r <= bitop_r[port_readback_pkg::bitop_port_pos]
                                      ? portb_view : porta_view;
                    bop_state_r <= port_readback_pkg::bop_write;
                end
                port_readback_pkg::bop_write:
                    bop_state_r <= port_readback_pkg::bop_idle;
                default:
                    bop_state_r <= port_readback_pkg::bop_idle;
            endcase
        end
    end

    // ------------------------------------------------------------
    // port data, direction, wake enable, analog control
    // ------------------------------------------------------------
    logic bop_wr;
    assign bop_wr = clk_en && bop_state_r == port_readback_pkg::bop_write;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            porta_data_r <= port_readback_pkg::data_reset;
            portb_data_r <= port_readback_pkg::data_reset;
            porta_dir_r  <= port_readback_pkg::dir_reset;
            portb_dir_r  <= port_readback_pkg::dir_reset;
        end
        else if (bop_wr)
        begin
            case ({bitop_r[port_readback_pkg::bitop_dir_pos],
                   bitop_r[port_readback_pkg::bitop_port_pos]})
                2'd0:    porta_data_r <= bop_mod;
                2'd1:    portb_data_r <= bop_mod;
                2'd2:    porta_dir_r  <= bop_mod;
                default: portb_dir_r  <= bop_mod;
            endcase
        end
        else if (wr_en)
        begin
            case (paddr)
                port_readback_pkg::off_porta_data: porta_data_r <= pwdata[port_width-1:0];
                port_readback_pkg::off_portb_data: portb_data_r <= pwdata[port_width-1:0];
                port_readback_pkg::off_porta_dir:  porta_dir_r  <= pwdata[port_width-1:0];
                port_readback_pkg::off_portb_dir:  portb_dir_r  <= pwdata[port_width-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            porta_wake_enable_r <= port_readback_pkg::wake_reset;
            chan_sel_r          <= 2'b00;
            analog_fn_sel_r     <= 2'b00;
        end
        else if (wr_en && paddr == port_readback_pkg::off_porta_wake)
            porta_wake_enable_r <= pwdata[port_width-1:0];
        else if (wr_en && paddr == port_readback_pkg::off_analog_ctrl)
        begin
            chan_sel_r      <= pwdata[port_readback_pkg::chan_sel_pos +: 2];
            analog_fn_sel_r <= pwdata[port_readback_pkg::ana_sel_lsb +: 2];
        end
    end

    // ------------------------------------------------------------
    // pin drive, analog switches, wake
    // ------------------------------------------------------------
    // readback mode only forces the analog switches here: drive stays as configured
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            porta_out        <= '1;
            portb_out        <= '1;
            porta_oen_n      <= '1;
            portb_oen_n      <= '1;
            analog_switch_on <= 2'b00;
            wake_req         <= 1'b0;
            porta_prev_r     <= '1;
        end
        else if (clk_en)
        begin
            porta_out    <= porta_data_r;
            portb_out    <= portb_data_r;
            porta_oen_n  <= porta_dir_r;
            portb_oen_n  <= portb_dir_r;
            porta_prev_r <= porta_in;
            for (int c = 0; c < 2; c++)
                analog_switch_on[c] <= analog_fn_sel_r[c]
                                       || (pin_readback_mode_r && chan_sel_r[c]);
            wake_req <= sleep_mode
                        && |(porta_prev_r & ~porta_in & porta_wake_enable_r);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_key_sets_mode: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == port_readback_pkg::off_readback_key
        && pwdata[7:0] == port_readback_pkg::key_pattern |=> pin_readback_mode_r)
        else $error("key pattern did not enable readback");
    a_other_clears_mode: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == port_readback_pkg::off_readback_key
        && pwdata[7:0] != port_readback_pkg::key_pattern |=> !pin_readback_mode_r)
        else $error("other value left readback enabled");
    a_read_pins: assert property (@(posedge pclk) disable iff (!presetn)
        pin_readback_mode_r |-> porta_view == porta_in && portb_view == portb_in)
        else $error("readback view is not the pins");
    a_drive_stable: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && $stable(porta_dir_r) |=> porta_oen_n == $past(porta_dir_r))
        else $error("pin drive changed by read mode");
    a_out_latch: assert property (@(posedge pclk) disable iff (!presetn)
        !pin_readback_mode_r && porta_digout_fn[0] && !porta_ana[0]
        |-> porta_view[0] == (porta_dir_r[0] ? 1'b0 : porta_data_r[0]))
        else $error("output pin read wrong");
    a_switch_open: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !pin_readback_mode_r && !analog_fn_sel_r[0] |=> !analog_switch_on[0])
        else $error("analog switch closed without selection");
    a_switch_forced: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && pin_readback_mode_r && chan_sel_r[1] |=> analog_switch_on[1])
        else $error("readback did not force analog switch");
    a_bitop_rmw: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && bop_state_r == port_readback_pkg::bop_read
        |=> bop_state_r == port_readback_pkg::bop_write)
        else $error("bit operation sequence broken");
    a_wake_fall: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && sleep_mode && (porta_prev_r[2] && !porta_in[2] && porta_wake_enable_r[2])
        |=> wake_req)
        else $error("falling edge did not wake");

    c_mode_on:  cover property (@(posedge pclk) disable iff (!presetn) $rose(pin_readback_mode_r));
    c_bitop:    cover property (@(posedge pclk) disable iff (!presetn) bop_wr);
    c_wake:     cover property (@(posedge pclk) disable iff (!presetn) wake_req);
    c_force_sw: cover property (@(posedge pclk) disable iff (!presetn)
        pin_readback_mode_r && analog_switch_on[0] && !analog_fn_sel_r[0]);

endmodule
`default_nettype wire

// file: logic/port_readback_pkg.sv
// Purpose: shared constants for the port readback / self-test block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   offsets other than the key register are chosen locally
package port_readback_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] off_readback_key = 8'h00;
    localparam logic [7:0] off_porta_data   = 8'h04;
    localparam logic [7:0] off_porta_dir    = 8'h08;
    localparam logic [7:0] off_portb_data   = 8'h0c;
    localparam logic [7:0] off_portb_dir    = 8'h10;
    localparam logic [7:0] off_porta_wake   = 8'h14;
    localparam logic [7:0] off_porta_read   = 8'h18;
    localparam logic [7:0] off_portb_read   = 8'h1c;
    localparam logic [7:0] off_analog_ctrl  = 8'h20;
    localparam logic [7:0] off_bit_op       = 8'h24;
    localparam logic [7:0] off_status       = 8'h28;

    // ------------------------------------------------------------
    // values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] key_pattern      = 8'hca;
    localparam logic [7:0] key_reset        = 8'h00;
    localparam logic [7:0] data_reset       = 8'hff;
    localparam logic [7:0] dir_reset        = 8'hff;
    localparam logic [7:0] wake_reset       = 8'h00;
    localparam int         bitop_idx_lsb    = 0;
    localparam int         bitop_val_pos    = 3;
    localparam int         bitop_port_pos   = 4;
    localparam int         bitop_dir_pos    = 5;
    localparam int         chan_sel_pos     = 0;
    localparam int         ana_sel_lsb      = 4;

    // bit-operation sequence states
    typedef enum logic [2:0]
    {
        bop_idle  = 3'b001,
        bop_read  = 3'b010,
        bop_write = 3'b100
    } bop_state_type;

endpackage

// file: test/pin_partner.sv
// Purpose: far-side model of one port's pins
// Assumes: an output-driving pin shows its latch level
// Notes:   undriven pins follow the level the bench applies externally
`timescale 1ns/1ns
`default_nettype none
module pin_partner
#(
    parameter int port_width = 8
)
(
    // pad side of the block
    input  wire logic [port_width-1:0] port_out,
    input  wire logic [port_width-1:0] port_oen_n,
    // external circuitry
    input  wire logic [port_width-1:0] ext_level,
    output logic      [port_width-1:0] pin_level
);
    // the block's drive wins over the external load on an output pin
    always_comb
    begin
        for (int i = 0; i < port_width; i++)
        begin
            pin_level[i] = (port_oen_n[i] == 1'b0) ? port_out[i] : ext_level[i];
        end
    end
endmodule
`default_nettype wire

// file: test/port_readback_selftest_bench.sv
// Purpose: self-checking bench for the port readback block
// Assumes: apb slave with one wait state; pins resolved by pin_partner
// Notes:   port B output-function select is tied; clk_en drops once in the wake test
`timescale 1ns/1ns
`default_nettype none
module port_readback_selftest_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, porta_out, porta_oen_n, portb_out, portb_oen_n, porta_in, portb_in;
    logic [7:0]  porta_ext, portb_ext, porta_digout_fn, v;
    logic [31:0] pwdata, prdata;
    logic        sleep_mode, wake_req, err, clk_en;
    logic [1:0]  analog_switch_on;
    int          n_fail, num_checks;

    port_readback uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .porta_in(porta_in), .porta_out(porta_out),
        .porta_oen_n(porta_oen_n), .portb_in(portb_in), .portb_out(portb_out),
        .portb_oen_n(portb_oen_n), .porta_digout_fn(porta_digout_fn),
        .portb_digout_fn(8'h00), .sleep_mode(sleep_mode), .wake_req(wake_req),
        .analog_switch_on(analog_switch_on));
    pin_partner pa (.port_out(porta_out), .port_oen_n(porta_oen_n), .ext_level(porta_ext),
        .pin_level(porta_in));
    pin_partner pb (.port_out(portb_out), .port_oen_n(portb_oen_n), .ext_level(portb_ext),
        .pin_level(portb_in));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // ------------------------------------------------------------
    // apb master
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_fail++;
            $display("[FAIL] %0t apb answer missing", $time);
            tally_and_finish();
        end
        v = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] offs [7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h00, 8'h28};
        logic [7:0] exps [7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++)
        begin
            xfer(1'b0, offs[i], 8'h00);
            chk(v, exps[i], "reset value");
        end
        chk(porta_oen_n, 8'hff, "pins start as inputs");
        xfer(1'b0, 8'h3c, 8'h00);
        chk({7'h0, err}, 8'h01, "unmapped error");
        $display("test reset done");
    endtask

    task automatic t_key;
        xfer(1'b1, port_readback_pkg::off_readback_key, 8'hca);
        xfer(1'b0, port_readback_pkg::off_status, 8'h00);
        chk(v & 8'h01, 8'h01, "mode on after key");
        xfer(1'b1, port_readback_pkg::off_readback_key, 8'h4a);
        xfer(1'b0, port_readback_pkg::off_status, 8'h00);
        chk(v & 8'h01, 8'h00, "mode off after other value");
        $display("test key done");
    endtask

    task automatic t_view;
        porta_ext <= 8'ha5;
        porta_digout_fn <= 8'h3c;
        xfer(1'b1, port_readback_pkg::off_porta_data, 8'h3c);
        xfer(1'b1, port_readback_pkg::off_porta_dir, 8'h0f);
        xfer(1'b0, port_readback_pkg::off_porta_read, 8'h00);
        chk(v, 8'h31, "latch path view");
        xfer(1'b1, port_readback_pkg::off_readback_key, 8'hca);
        xfer(1'b0, port_readback_pkg::off_porta_read, 8'h00);
        chk(v, 8'h35, "pin path view");
        chk(porta_out, 8'h3c, "drive kept in mode");
        chk(porta_oen_n, 8'h0f, "direction kept in mode");
        xfer(1'b1, port_readback_pkg::off_readback_key, 8'h00);
        $display("test view done");
    endtask

    task automatic t_bitop;
        xfer(1'b1, port_readback_pkg::off_bit_op, 8'h30);
        repeat (4) @(posedge pclk);
        xfer(1'b0, port_readback_pkg::off_portb_dir, 8'h00);
        chk(v, 8'hfe, "clear dir bit");
        xfer(1'b1, port_readback_pkg::off_bit_op, 8'h0f);
        repeat (4) @(posedge pclk);
        xfer(1'b0, port_readback_pkg::off_porta_data, 8'h00);
        chk(v, 8'hb1, "whole port written back");
        xfer(1'b1, port_readback_pkg::off_porta_dir, 8'hff);
        $display("test bit op done");
    endtask

    task automatic t_analog;
        logic [7:0] key [4] = '{8'h00, 8'h00, 8'hca, 8'hca};
        logic [7:0] ctl [4] = '{8'h01, 8'h10, 8'h01, 8'h02};
        logic [7:0] exp [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b1, port_readback_pkg::off_readback_key, key[i]);
            xfer(1'b1, port_readback_pkg::off_analog_ctrl, ctl[i]);
            repeat (3) @(posedge pclk);
            chk({6'h0, analog_switch_on}, exp[i], "analog switch");
        end
        xfer(1'b1, port_readback_pkg::off_readback_key, 8'h00);
        $display("test analog done");
    endtask

    task automatic t_wake;
        int n;
        porta_ext <= 8'hff;
        sleep_mode <= 1'b1;
        xfer(1'b1, port_readback_pkg::off_porta_wake, 8'h04);
        repeat (3) @(posedge pclk);
        porta_ext <= 8'hf7;
        n = 0;
        repeat (6)
        begin
            @(posedge pclk);
            if (wake_req === 1'b1)
                n++;
        end
        chk(n[7:0], 8'h00, "disabled pin no wake");
        porta_ext <= 8'hf3;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (wake_req !== 1'b1 && n < 6);
        chk({7'h0, wake_req}, 8'h01, "enabled pin wakes");
        // an edge seen while frozen must neither wake nor be lost
        porta_ext <= 8'hff;
        repeat (2) @(posedge pclk);
        clk_en <= 1'b0;
        porta_ext <= 8'hfb;
        n = 0;
        repeat (4)
        begin
            @(posedge pclk);
            if (wake_req === 1'b1)
                n++;
        end
        chk(n[7:0], 8'h00, "no wake while frozen");
        clk_en <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (wake_req !== 1'b1 && n < 4);
        chk({7'h0, wake_req}, 8'h01, "edge kept across freeze");
        $display("test wake done");
    endtask

    initial
    begin
        n_fail = 0;
        num_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        porta_ext = 8'hff;
        portb_ext = 8'h5a;
        porta_digout_fn = 8'h00;
        sleep_mode = 1'b0;
        clk_en = 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_key();
        t_view();
        t_bitop();
        t_analog();
        t_wake();
        tally_and_finish();
    end
endmodule
`default_nettype wire
